// >>> config_loader.sv
`timescale 1ns/1ps
`default_nettype none
module config_loader #(
    parameter int FLASH_BYTES = pmem_pkg::FLASH_128K
) (
    input wire logic clk,
    input wire logic resetn,
    output logic flash_rd,
    output logic [19:0] flash_word_addr,
    input wire logic [15:0] flash_rdata,
    output logic load_done,
    output logic [15:0] cfg_word1,
    output logic [15:0] cfg_word2,
    output logic [15:0] cfg_word3
);
    localparam int BASE_BYTE = FLASH_BYTES - pmem_pkg::CFG_AREA_BYTES;
    localparam logic [19:0] BASE_WORD = 20'(BASE_BYTE / 2);

    logic [15:0] word_mem [pmem_pkg::CFG_WORDS];
    logic [2:0] index_reg;
    logic capture_reg;
    logic done_reg;
    logic [1:0] slot_reg;

    // One read per cycle, captured the cycle after; four words in order
    assign flash_rd = !done_reg && (index_reg < 3'(pmem_pkg::CFG_WORDS));
    assign flash_word_addr = BASE_WORD + 20'(index_reg);
    assign load_done = done_reg;

    // Sequencer for the top-of-flash copy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            index_reg <= 3'h0;
            capture_reg <= 1'b0;
            slot_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            capture_reg <= flash_rd;
            slot_reg <= index_reg[1:0];
            if (flash_rd) begin
                index_reg <= index_reg + 3'h1;
            end
            if (capture_reg && slot_reg == 2'h3) begin
                done_reg <= 1'b1;
            end
        end
    end

    // Word k lands in slot k: ascending address, low byte first
    always_ff @(posedge clk) begin
        if (capture_reg) begin
            word_mem[slot_reg] <= flash_rdata;
        end
    end

    // Fourth word is reserved and never leaves this module
    assign cfg_word1 = done_reg ? word_mem[0] : 16'hffff;
    assign cfg_word2 = done_reg ? word_mem[1] : 16'hffff;
    assign cfg_word3 = done_reg ? word_mem[2] : 16'hffff;
endmodule // config_loader
`default_nettype wire

// >>> ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ext_req,
    input wire logic [20:0] ext_addr,
    input wire logic [3:0] delay,
    output logic ext_ack,
    output logic [15:0] ext_rdata
);
    logic [3:0] wait_reg;
    // Answer delay+1 cycles after the request; data flips on every cycle without an ack so stale reads show
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= 4'h0;
            ext_ack <= 1'h0;
            ext_rdata <= 16'h0;
        end else if (ext_req && !ext_ack && wait_reg == delay) begin
            ext_ack <= 1'h1;
            ext_rdata <= ext_addr[15:0] ^ 16'ha5c3;
            wait_reg <= 4'h0;
        end else begin
            ext_ack <= 1'h0;
            ext_rdata <= ~ext_rdata;
            wait_reg <= (ext_req && !ext_ack) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule // ext_mem_model
`default_nettype wire

// >>> pmem_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pmem_checker #(
    parameter int FLASH_BYTES = pmem_pkg::FLASH_128K
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pc_step,
    input wire logic pc_load,
    input wire pmem_pkg::vector_sel_t vector_sel,
    input wire logic [20:0] pc,
    input wire logic req_valid,
    input wire logic req_use_pc,
    input wire logic [20:0] req_addr,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic [15:0] resp_data,
    input wire logic flash_rd,
    input wire logic [19:0] flash_word_addr,
    input wire logic ext_bus_enable,
    input wire logic ext_req,
    input wire logic [1:0] ext_addr_width
);
    logic loaded_reg;
    // Address a request really asks for
    wire [20:0] eff = req_use_pc ? pc : req_addr;
    wire taken = req_valid && req_ready && loaded_reg;
    // Loader owns the pc until req_ready first shows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loaded_reg <= 1'h0;
        end else if (req_ready) begin
            loaded_reg <= 1'h1;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    reset_vector_a: assert property ($rose(resetn) |-> pc == 21'h0)
        else $error("pc not at reset vector");
    high_vector_a: assert property (loaded_reg &&
        vector_sel == pmem_pkg::VEC_HIGH |=> pc == 21'h8)
        else $error("high vector missed");
    low_vector_a: assert property (loaded_reg &&
        vector_sel == pmem_pkg::VEC_LOW |=> pc == 21'h18)
        else $error("low vector missed");
    pc_step_a: assert property (loaded_reg && pc_step && !pc_load &&
        vector_sel == pmem_pkg::VEC_NONE |=> pc == $past(pc) + 21'h2)
        else $error("pc step wrong");
    zero_fill_a: assert property (taken && !ext_bus_enable &&
        eff >= FLASH_BYTES |=> resp_valid && resp_data == 16'h0)
        else $error("zero region not zero");
    flash_route_a: assert property (taken && eff < FLASH_BYTES |->
        flash_rd && flash_word_addr == eff[20:1] ##2 resp_valid)
        else $error("flash fetch misrouted");
    ext_route_a: assert property (taken && ext_bus_enable &&
        eff >= FLASH_BYTES |=> ext_req)
        else $error("external fetch misrouted");
    mode_enable_a: assert property (ext_bus_enable ==
        (ext_addr_width != pmem_pkg::MODE_ON_CHIP))
        else $error("bus enable disagrees with mode");
endmodule // pmem_checker
bind program_memory_map pmem_checker #(.FLASH_BYTES(FLASH_BYTES))
    i_checker (.*);
`default_nettype wire

// >>> pmem_pkg.sv
package pmem_pkg;
    // Program space
    localparam int PC_WIDTH = 21;
    localparam logic [20:0] SPACE_TOP = 21'h1fffff;
    localparam logic [20:0] RESET_VECTOR = 21'h000000;
    localparam logic [20:0] HIGH_VECTOR = 21'h000008;
    localparam logic [20:0] LOW_VECTOR = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    // Flash sizes in bytes, and the reserved configuration area
    localparam int FLASH_32K = 32'h0000_8000;
    localparam int FLASH_64K = 32'h0001_0000;
    localparam int FLASH_96K = 32'h0001_8000;
    localparam int FLASH_128K = 32'h0002_0000;
    localparam int CFG_AREA_BYTES = 8;
    localparam int CFG_WORDS = 4;
    localparam int CFG_USED_WORDS = 3;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG_WORD1 = 8'h00;
    localparam logic [7:0] OFS_CFG_WORD2 = 8'h04;
    localparam logic [7:0] OFS_EXT_BUS_CFG = 8'h08;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PC = 8'h14;
    // external_bus_config_low fields
    localparam int BIT_WAIT_DIS = 7;
    localparam int BIT_BUS_WIDTH = 6;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_ADDR_SHIFT = 3;
    localparam logic [7:0] EXT_CFG_RESET = 8'hf8;
    localparam logic [7:0] EXT_CFG_MASK = 8'hf8;
    // memory_control_register fields and reset
    localparam int BIT_WAIT_HI = 5;
    localparam int BIT_WAIT_LO = 4;
    localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
    // memory_bus_config_field codes
    localparam logic [1:0] MODE_ON_CHIP = 2'b11;
    localparam logic [1:0] MODE_EXT_A12 = 2'b10;
    localparam logic [1:0] MODE_EXT_A16 = 2'b01;
    localparam logic [1:0] MODE_EXT_A20 = 2'b00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {VEC_NONE, VEC_HIGH, VEC_LOW} vector_sel_t;
endpackage

// >>> program_memory_map.sv
// Behaviour
// - Program counter is 21 bits, covering a 2 MB byte-addressed space.
// - Reads above implemented memory but below 2 MB return zeros.
// - Every reset loads the program counter with address zero.
// - High-priority interrupts vector to 0x0008, low-priority to 0x0018.
// - Top four instruction words of flash hold configuration, not code.
// - At reset, configuration words are copied from flash before use.
// - Config bytes ascend from first word low byte; fourth word reserved.
// - Config area is the last eight bytes of on-chip flash.
// - On-chip-only mode reads flash alone; above its top returns zeros.
// - Extended mode maps flash first, then external memory, routed.
// - Bits 5:4: 11 on-chip only; 10/01/00 external 12/16/20-bit address.
// - Small package is on-chip only; bus fields exist only on large one.
// - Bit 7 set disables waits; clear takes wait count from control 5:4.
// - Bit 6 selects 16-bit external data when set, 8-bit when clear.
// - Bit 3 set shifts external addresses to start at zero.
// - Data RAM access is never blocked by program memory configuration.
// - With shifting, subtract flash size before driving the external bus.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module program_memory_map #(
    parameter int FLASH_BYTES = pmem_pkg::FLASH_128K,
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Program counter control from the core
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [20:0] pc_load_value,
    input wire pmem_pkg::vector_sel_t vector_sel,
    output logic [20:0] pc,
    // Program memory read requests (fetch at pc, or table read)
    input wire logic req_valid,
    input wire logic req_use_pc,
    input wire logic [20:0] req_addr,
    output logic req_ready,
    output logic resp_valid,
    output logic [15:0] resp_data,
    // On-chip flash, one cycle read latency, word addressed
    output logic flash_rd,
    output logic [19:0] flash_word_addr,
    input wire logic [15:0] flash_rdata,
    // External memory bus controller
    output logic ext_bus_enable,
    output logic ext_req,
    output logic [20:0] ext_addr,
    input wire logic ext_ack,
    input wire logic [15:0] ext_rdata,
    output logic ext_data_16bit,
    output logic [1:0] ext_wait_states,
    output logic [1:0] ext_addr_width,
    // Data RAM path passes straight through
    input wire logic data_ram_req,
    output logic data_ram_grant
);
    localparam logic [20:0] FLASH_TOP = 21'(FLASH_BYTES);

    typedef enum {ST_LOAD, ST_IDLE, ST_FLASH, ST_EXT} state_t;

    state_t state_reg;
    state_t state_next;
    logic [20:0] pc_reg;
    logic [20:0] addr_reg;
    logic [20:0] ext_addr_reg;
    logic [15:0] resp_data_reg;
    logic resp_valid_reg;
    logic [7:0] ext_cfg_reg;
    logic ext_cfg_written_reg;
    logic [7:0] mem_ctrl_reg;
    logic load_done;
    logic load_rd;
    logic [19:0] load_word_addr;
    logic [15:0] cfg_word1;
    logic [15:0] cfg_word2;
    logic [15:0] cfg_word3;
    logic load_done_d_reg;

    // Copies the reserved top-of-flash words at reset
    config_loader #(.FLASH_BYTES(FLASH_BYTES)) u_loader (
        .clk(clk),
        .resetn(resetn),
        .flash_rd(load_rd),
        .flash_word_addr(load_word_addr),
        .flash_rdata(flash_rdata),
        .load_done(load_done),
        .cfg_word1(cfg_word1),
        .cfg_word2(cfg_word2),
        .cfg_word3(cfg_word3)
    );

    // Effective configuration; small package forces on-chip only
    wire [7:0] ext_cfg_eff = LARGE_PACKAGE ? ext_cfg_reg : 8'h00;
    wire [1:0] mode_field = LARGE_PACKAGE ?
        ext_cfg_reg[pmem_pkg::BIT_MODE_HI:pmem_pkg::BIT_MODE_LO] :
        pmem_pkg::MODE_ON_CHIP;
    wire extended_mode = (mode_field != pmem_pkg::MODE_ON_CHIP);
    wire on_chip_only_mode = !extended_mode;
    wire wait_disable = ext_cfg_eff[pmem_pkg::BIT_WAIT_DIS];
    wire bus_width_select = ext_cfg_eff[pmem_pkg::BIT_BUS_WIDTH];
    wire address_shift_enable = ext_cfg_eff[pmem_pkg::BIT_ADDR_SHIFT];

    // Address width as a bit mask for the external bus
    function automatic logic [20:0] width_mask(input logic [1:0] code);
        unique case (code)
            pmem_pkg::MODE_EXT_A12: width_mask = 21'h000fff;
            pmem_pkg::MODE_EXT_A16: width_mask = 21'h00ffff;
            pmem_pkg::MODE_EXT_A20: width_mask = 21'h0fffff;
            pmem_pkg::MODE_ON_CHIP: width_mask = 21'h000000;
        endcase
    endfunction

    // Request decode: which memory answers a given address
    wire [20:0] req_target = req_use_pc ? pc_reg : req_addr;
    wire target_in_flash = req_target < FLASH_TOP;
    wire target_external = !target_in_flash && extended_mode;
    wire [20:0] shifted_addr = address_shift_enable ?
        req_target - FLASH_TOP : req_target;
    wire req_take = req_valid && req_ready;

    assign req_ready = (state_reg == ST_IDLE) && !resp_valid_reg;

    // Fetch sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_LOAD: begin
                if (load_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_take && target_in_flash) begin
                    state_next = ST_FLASH;
                end else if (req_take && target_external) begin
                    state_next = ST_EXT;
                end
            end
            ST_FLASH: state_next = ST_IDLE;
            ST_EXT: begin
                if (ext_ack) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_LOAD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Flash port belongs to the loader until the copy is done
    assign flash_rd = load_done ? (req_take && target_in_flash) : load_rd;
    assign flash_word_addr = load_done ? req_target[20:1] : load_word_addr;

    // Address and answer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= 21'h000000;
            ext_addr_reg <= 21'h000000;
            resp_valid_reg <= 1'b0;
            resp_data_reg <= 16'h0000;
        end else begin
            resp_valid_reg <= 1'b0;
            if (req_take) begin
                addr_reg <= req_target;
                ext_addr_reg <= shifted_addr & width_mask(mode_field);
            end
            if (req_take && !target_in_flash && !target_external) begin
                resp_valid_reg <= 1'b1;
                resp_data_reg <= 16'h0000;
            end
            if (state_reg == ST_FLASH) begin
                resp_valid_reg <= 1'b1;
                resp_data_reg <= flash_rdata;
            end
            if (state_reg == ST_EXT && ext_ack) begin
                resp_valid_reg <= 1'b1;
                resp_data_reg <= ext_rdata;
            end
        end
    end

    assign resp_valid = resp_valid_reg;
    assign resp_data = resp_data_reg;
    assign ext_req = (state_reg == ST_EXT);
    assign ext_addr = ext_addr_reg;
    assign ext_bus_enable = extended_mode;
    assign ext_data_16bit = bus_width_select;
    assign ext_addr_width = mode_field;
    assign ext_wait_states = wait_disable ? 2'b00 :
        mem_ctrl_reg[pmem_pkg::BIT_WAIT_HI:pmem_pkg::BIT_WAIT_LO];
    // Data RAM sits on its own bus; nothing here may stall it
    assign data_ram_grant = data_ram_req;

    // Program counter; held at the reset vector until config is loaded
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_reg <= pmem_pkg::RESET_VECTOR;
        end else if (!load_done) begin
            pc_reg <= pmem_pkg::RESET_VECTOR;
        end else if (vector_sel == pmem_pkg::VEC_HIGH) begin
            pc_reg <= pmem_pkg::HIGH_VECTOR;
        end else if (vector_sel == pmem_pkg::VEC_LOW) begin
            pc_reg <= pmem_pkg::LOW_VECTOR;
        end else if (pc_load) begin
            pc_reg <= {pc_load_value[20:1], 1'b0};
        end else if (pc_step) begin
            pc_reg <= pc_reg + pmem_pkg::PC_STEP;
        end
    end
    assign pc = pc_reg;

    // Write channel: address and data may come in either order
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_strb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    wire aw_now = aw_held_reg || (s_axi_awvalid && s_axi_awready);
    wire w_now = w_held_reg || (s_axi_wvalid && s_axi_wready);
    wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire wr_lane0 = w_held_reg ? w_strb0_reg : s_axi_wstrb[0];
    wire wr_fire = aw_now && w_now && !bvalid_reg;
    wire wr_word = wr_addr[1:0] == 2'b00;
    wire wr_to_ext_cfg = wr_word && wr_addr == pmem_pkg::OFS_EXT_BUS_CFG;
    wire wr_to_mem_ctrl = wr_word && wr_addr == pmem_pkg::OFS_MEM_CTRL;
    wire wr_mapped = wr_to_ext_cfg || wr_to_mem_ctrl;
    // A second write to the write-once field is ignored, still OKAY
    wire ext_cfg_take = wr_fire && wr_to_ext_cfg && wr_lane0 &&
        !ext_cfg_written_reg && LARGE_PACKAGE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= pmem_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? pmem_pkg::RESP_OKAY :
                    pmem_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Configuration byte: 0xf8 at power up, then flash copy, then one write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_cfg_reg <= pmem_pkg::EXT_CFG_RESET;
            ext_cfg_written_reg <= 1'b0;
            load_done_d_reg <= 1'b0;
            mem_ctrl_reg <= pmem_pkg::MEM_CTRL_RESET;
        end else begin
            load_done_d_reg <= load_done;
            if (load_done && !load_done_d_reg) begin
                ext_cfg_reg <= cfg_word3[7:0] & pmem_pkg::EXT_CFG_MASK;
            end else if (ext_cfg_take) begin
                ext_cfg_reg <= wr_data[7:0] & pmem_pkg::EXT_CFG_MASK;
                ext_cfg_written_reg <= 1'b1;
            end
            if (wr_fire && wr_to_mem_ctrl && wr_lane0) begin
                mem_ctrl_reg <= wr_data[7:0];
            end
        end
    end

    // Read channel: one cycle from address to data
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rd_value;
    logic rd_hit;

    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        rd_hit = 1'b1;
        rd_value = 32'h0000_0000;
        unique case (s_axi_araddr)
            pmem_pkg::OFS_CFG_WORD1: rd_value = {16'h0000, cfg_word1};
            pmem_pkg::OFS_CFG_WORD2: rd_value = {16'h0000, cfg_word2};
            pmem_pkg::OFS_EXT_BUS_CFG: rd_value = {24'h000000, ext_cfg_eff};
            pmem_pkg::OFS_MEM_CTRL: rd_value = {24'h000000, mem_ctrl_reg};
            pmem_pkg::OFS_STATUS: rd_value = {28'h0000000,
                ext_cfg_written_reg, load_done, extended_mode,
                on_chip_only_mode};
            pmem_pkg::OFS_PC: rd_value = {11'h000, pc_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= pmem_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_hit ? pmem_pkg::RESP_OKAY :
                pmem_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule // program_memory_map
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int FB = pmem_pkg::FLASH_32K;
    localparam logic [19:0] CFG_WORD = 20'((FB - 8) / 2);
    localparam logic [15:0] CFGW [4] = '{16'h1111, 16'h2222, 16'h5a18, 16'hffff};
    logic clk = 1'h0, resetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic pc_step = 1'h0, pc_load = 1'h0, req_valid = 1'h0, req_use_pc = 1'h0;
    logic data_ram_req = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, req_ready, resp_valid, flash_rd;
    logic ext_bus_enable, ext_req, ext_ack, ext_data_16bit, data_ram_grant;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h198e;
    logic [3:0] s_axi_wstrb = 4'hf, delay = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, ext_wait_states, ext_addr_width, r;
    logic [20:0] pc_load_value = 21'h0, req_addr = 21'h0, pc, ext_addr, a;
    logic [15:0] flash_rdata = 16'h0, resp_data, ext_rdata, d;
    logic [19:0] flash_word_addr;
    pmem_pkg::vector_sel_t vector_sel = pmem_pkg::VEC_NONE;
    int failures = 0, checks = 0, cycles = 0;

    program_memory_map #(.FLASH_BYTES(FB)) i_dut (.*);
    ext_mem_model i_ext (.*);

    always #10 clk = ~clk;
    // Flash: one-cycle latency, inverted junk when not strobed
    always @(posedge clk) begin
        flash_rdata <= flash_rd ? fword(flash_word_addr) : ~flash_rdata;
    end
    // Hang guard, and random traffic on the data RAM path
    always @(posedge clk) begin
        cycles <= cycles + 1;
        data_ram_req <= rnd[cycles[4:0]];
        if (cycles == 8000) begin
            failures++;
            wrap_up();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Top four words are configuration, the rest a known pattern
    function automatic logic [15:0] fword(input logic [19:0] w);
        if (w >= CFG_WORD) begin
            return CFGW[w[1:0]];
        end
        return w[15:0] ^ 16'h1234;
    endfunction
    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    // One register access; a read also compares the low half of its data
    task automatic xfer(input logic w, input logic [7:0] ad,
        input logic [31:0] v, input logic [1:0] er = pmem_pkg::RESP_OKAY);
        logic at, wt, bt;
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_araddr <= ad;
        s_axi_wdata <= v;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        forever begin
            @(negedge clk);
            at = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
            wt = s_axi_wvalid & s_axi_wready;
            bt = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
            r = w ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata[15:0];
            @(posedge clk);
            if (at) begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (wt) s_axi_wvalid <= 1'h0;
            if (bt) begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                check(w ? "write resp" : "read resp", er, r);
                if (!w) check("read data", v, d);
                return;
            end
        end
    endtask
    task automatic fetch(input logic [20:0] ad, input logic up);
        logic t;
        @(posedge clk);
        req_addr <= ad;
        req_use_pc <= up;
        req_valid <= 1'h1;
        do begin
            @(negedge clk);
            t = req_valid & req_ready;
            @(posedge clk);
        end while (t !== 1'h1);
        req_valid <= 1'h0;
        do @(negedge clk); while (resp_valid !== 1'h1);
        d = resp_data;
    endtask
    // One cycle of pc control, then the pc is compared
    task automatic pcop(input logic s, input logic l, input logic [20:0] v,
        input pmem_pkg::vector_sel_t vs, input logic [20:0] e);
        @(posedge clk);
        pc_step <= s;
        pc_load <= l;
        pc_load_value <= v;
        vector_sel <= vs;
        @(posedge clk);
        pc_step <= 1'h0;
        pc_load <= 1'h0;
        vector_sel <= pmem_pkg::VEC_NONE;
        @(negedge clk);
        check("pc", e, pc);
    endtask
    // After each reset: pc at zero, config copied from the flash top
    task automatic boot;
        @(negedge clk);
        check("pc", 21'h0, pc);
        while (req_ready !== 1'h1) @(negedge clk);
        xfer(1'h0, pmem_pkg::OFS_CFG_WORD1, CFGW[0]);
        xfer(1'h0, pmem_pkg::OFS_CFG_WORD2, CFGW[1]);
        xfer(1'h0, pmem_pkg::OFS_EXT_BUS_CFG, 16'h18);
        check("ram grant", data_ram_req, data_ram_grant);
        check("bus enable", 1'h1, ext_bus_enable);
        check("addr width", pmem_pkg::MODE_EXT_A16, ext_addr_width);
        check("data width", 1'h0, ext_data_16bit);
    endtask
    task automatic wrap_up;
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        boot();
        xfer(1'h1, pmem_pkg::OFS_MEM_CTRL, 32'h30);
        check("wait states", 2'h3, ext_wait_states);
        repeat (4) begin
            rnd = lfsr(rnd);
            a = 21'(rnd % (FB - 8)) & 21'h1ffffe;
            fetch(a, 1'h0);
            check("flash fetch", fword(a[20:1]), d);
        end
        // Prompt and slow external answers, address shifted down
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            delay <= 4'(i * 3);
            fetch(21'(FB) + {5'h0, rnd[15:1], 1'h0}, 1'h0);
            check("ext fetch", {rnd[15:1], 1'h0} ^ 16'ha5c3, d);
            check("ext addr", {rnd[15:1], 1'h0}, ext_addr);
        end
        pcop(1'h0, 1'h0, 21'h0, pmem_pkg::VEC_HIGH, 21'h8);
        fetch(21'h0, 1'h1);
        check("vector fetch", fword(20'h4), d);
        pcop(1'h1, 1'h0, 21'h0, pmem_pkg::VEC_LOW, 21'h18);
        pcop(1'h0, 1'h1, 21'h1ffffe, pmem_pkg::VEC_NONE, 21'h1ffffe);
        pcop(1'h1, 1'h0, 21'h0, pmem_pkg::VEC_NONE, 21'h0);
        rnd = lfsr(rnd);
        a = {rnd[20:1], 1'h0};
        pcop(1'h1, 1'h1, rnd[20:0], pmem_pkg::VEC_NONE, a);
        check("pc load", a, pc);
        // Write once, then a refused second write
        xfer(1'h1, pmem_pkg::OFS_EXT_BUS_CFG, 32'hf8);
        xfer(1'h0, pmem_pkg::OFS_EXT_BUS_CFG, 16'hf8);
        xfer(1'h1, pmem_pkg::OFS_EXT_BUS_CFG, 32'h07);
        xfer(1'h0, pmem_pkg::OFS_EXT_BUS_CFG, 16'hf8);
        check("bus enable", 1'h0, ext_bus_enable);
        check("wait states", 2'h0, ext_wait_states);
        check("data width", 1'h1, ext_data_16bit);
        fetch(21'(FB) + 21'h100, 1'h0);
        check("zero fetch", 16'h0, d);
        fetch(pmem_pkg::SPACE_TOP - 21'h1, 1'h0);
        check("top fetch", 16'h0, d);
        xfer(1'h0, 8'h40, 16'h0, pmem_pkg::RESP_SLVERR);
        @(posedge clk);
        resetn <= 1'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        boot();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
